//--- rtl/tcs_pkg.sv
// Constants for the transceiver control and status block.
// Assumes a 40 MHz system clock; times are kept in their own units.
package tcs_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;

  // Documented limits
  localparam int unsigned T_RESET_US    = 10;
  localparam int unsigned T_INIT_MS     = 300;
  localparam int unsigned T_SERIAL_MS   = 300;
  localparam int unsigned T_DATA_MS     = 1000;

  // Least hold time rounds up; longest times round down
  localparam logic [8:0]  T_RESET_CYC   =
    9'((T_RESET_US * (CLK_HZ / 1000) + 999) / 1000);
  localparam logic [25:0] T_INIT_CYC    = 26'(T_INIT_MS * (CLK_HZ / 1000));
  localparam logic [25:0] T_SERIAL_CYC  = 26'(T_SERIAL_MS * (CLK_HZ / 1000));
  localparam logic [25:0] T_DATA_CYC    = 26'(T_DATA_MS * (CLK_HZ / 1000));

  // Two-wire device addresses (7-bit) and the status/control byte
  localparam logic [6:0]  ID_ADDR       = 7'h50;
  localparam logic [6:0]  DIAG_ADDR     = 7'h51;
  localparam logic [7:0]  DIAG_CTRL_STATUS_OFFSET = 8'h6E;
  localparam logic [7:0]  DIAG_CTRL_STATUS_RESET  = 8'h01;

  // Field positions within the status/control byte
  localparam int unsigned HW_DISABLE_BIT   = 7;
  localparam int unsigned SOFT_DISABLE_BIT = 6;
  localparam int unsigned FAULT_BIT        = 2;
  localparam int unsigned LOST_BIT         = 1;
  localparam int unsigned NOT_READY_BIT    = 0;

  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    TCS_IDLE    = 3'h0,
    TCS_ADDR    = 3'h1,
    TCS_ADDR_AK = 3'h3,
    TCS_WR      = 3'h2,
    TCS_WR_AK   = 3'h6,
    TCS_RD      = 3'h7,
    TCS_RD_AK   = 3'h5
  } tcs_bus_e;

endpackage : tcs_pkg

//--- rtl/tcs_top.sv
// Transceiver control/status logic with two-wire serial register access.
// Assumes the pins and the serial bus are asynchronous to i_clk; SDA is
// open drain and resolved outside.
`timescale 1ns/1ps
module tcs_top #(
  parameter logic [25:0] P_INIT_CYC   = tcs_pkg::T_INIT_CYC,
  parameter logic [25:0] P_SERIAL_CYC = tcs_pkg::T_SERIAL_CYC,
  parameter logic [25:0] P_DATA_CYC   = tcs_pkg::T_DATA_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_tx_disable,
  input  wire logic i_laser_fault,
  input  wire logic i_signal_present,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  output logic      o_laser_on,
  output logic      o_tx_fault,
  output logic      o_receive_signal_lost
);

  typedef struct packed {
    logic              scl_m;
    logic              scl_s;
    logic              scl_q;
    logic              sda_m;
    logic              sda_s;
    logic              sda_q;
    logic              dis_m;
    logic              dis_s;
    logic              dis_q;
    logic              flt_m;
    logic              flt_s;
    logic              sig_m;
    logic              sig_s;
    logic [25:0]       pu_cnt;
    logic              init_done;
    logic              bus_ready;
    logic              data_ready;
    logic [8:0]        rst_cnt;
    logic              fault;
    logic              soft_dis;
    logic              laser_on;
    logic              lost;
    tcs_pkg::tcs_bus_e st;
    logic [3:0]        cnt;
    logic [7:0]        shreg;
    logic [7:0]        ptr;
    logic              dev_diag;
    logic              rw;
    logic              first;
    logic              nack;
    logic              pend;
    logic              pend_val;
    logic              sda_drive;
    logic              sda_out;
  } tcs_state_s;

  localparam tcs_state_s RESET_STATE = '{
    scl_m: 1'b1, scl_s: 1'b1, scl_q: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_q: 1'b1,
    dis_m: 1'b1, dis_s: 1'b1, dis_q: 1'b1,
    flt_m: 1'b0, flt_s: 1'b0,
    sig_m: 1'b0, sig_s: 1'b0,
    pu_cnt: 26'h0000000,
    init_done: 1'b0, bus_ready: 1'b0, data_ready: 1'b0,
    rst_cnt: 9'h000,
    fault: 1'b0,
    soft_dis: tcs_pkg::DIAG_CTRL_STATUS_RESET[tcs_pkg::SOFT_DISABLE_BIT],
    laser_on: 1'b0,
    lost: 1'b1,
    st: tcs_pkg::TCS_IDLE,
    cnt: 4'h0,
    shreg: 8'h00,
    ptr: 8'h00,
    dev_diag: 1'b0, rw: 1'b0, first: 1'b0, nack: 1'b0,
    pend: 1'b0, pend_val: 1'b0,
    sda_drive: 1'b0, sda_out: 1'b0
  };

  tcs_state_s s;
  tcs_state_s next_s;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       addr_hit;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  assign scl_rise  = s.scl_s & ~s.scl_q;
  assign scl_fall  = ~s.scl_s & s.scl_q;
  assign bus_start = s.scl_s & s.scl_q & s.sda_q & ~s.sda_s;
  assign bus_stop  = s.scl_s & s.scl_q & ~s.sda_q & s.sda_s;

  // Only the two module addresses answer, and only once the bus is ready
  assign addr_hit = s.bus_ready &&
                    (s.shreg[7:1] == tcs_pkg::ID_ADDR ||
                     s.shreg[7:1] == tcs_pkg::DIAG_ADDR);

  always_comb begin
    status_byte = 8'h00;
    status_byte[tcs_pkg::HW_DISABLE_BIT]   = s.dis_s;
    status_byte[tcs_pkg::SOFT_DISABLE_BIT] = s.soft_dis;
    status_byte[tcs_pkg::FAULT_BIT]        = s.fault;
    status_byte[tcs_pkg::LOST_BIT]         = s.lost;
    status_byte[tcs_pkg::NOT_READY_BIT]    = ~s.data_ready;
  end

  // Identification page content is not held here and reads as zero
  assign rd_byte = (s.dev_diag && s.ptr == tcs_pkg::DIAG_CTRL_STATUS_OFFSET)
                   ? status_byte : 8'h00;

  always_comb begin
    next_s = s;

    // Two-flop synchronisers, then edge history
    next_s.scl_m = i_scl;
    next_s.scl_s = s.scl_m;
    next_s.scl_q = s.scl_s;
    next_s.sda_m = i_sda;
    next_s.sda_s = s.sda_m;
    next_s.sda_q = s.sda_s;
    next_s.dis_m = i_tx_disable;
    next_s.dis_s = s.dis_m;
    next_s.dis_q = s.dis_s;
    next_s.flt_m = i_laser_fault;
    next_s.flt_s = s.flt_m;
    next_s.sig_m = i_signal_present;
    next_s.sig_s = s.sig_m;

    // Power-up sequencing
    if (s.pu_cnt != 26'h3FFFFFF) begin
      next_s.pu_cnt = s.pu_cnt + 26'h0000001;
    end
    if (s.pu_cnt >= P_INIT_CYC) begin
      next_s.init_done = 1'b1;
    end
    if (s.pu_cnt >= P_SERIAL_CYC) begin
      next_s.bus_ready = 1'b1;
    end
    if (s.pu_cnt >= P_DATA_CYC) begin
      next_s.data_ready = 1'b1;
    end

    // Hold time of transmit-off, needed to reset a latched fault
    if (s.dis_s) begin
      if (s.rst_cnt != tcs_pkg::T_RESET_CYC) begin
        next_s.rst_cnt = s.rst_cnt + 9'h001;
      end
    end else begin
      next_s.rst_cnt = 9'h000;
    end

    // Fault latch: clear on release after a long enough hold; set wins
    if (s.dis_q && !s.dis_s && s.rst_cnt == tcs_pkg::T_RESET_CYC) begin
      next_s.fault = 1'b0;
    end
    if (s.flt_s && !s.dis_s && s.init_done) begin
      next_s.fault = 1'b1;
    end

    // Laser drive follows both disables and the fault latch
    next_s.laser_on = s.init_done & ~s.dis_s
                      & ~s.soft_dis & ~s.fault;
    next_s.lost = ~s.sig_s;

    // Two-wire slave
    if (bus_start) begin
      next_s.st        = tcs_pkg::TCS_ADDR;
      next_s.cnt       = 4'h0;
      next_s.sda_drive = 1'b0;
    end else if (bus_stop) begin
      next_s.st        = tcs_pkg::TCS_IDLE;
      next_s.sda_drive = 1'b0;
      if (s.pend) begin
        next_s.soft_dis = s.pend_val;
        next_s.pend     = 1'b0;
      end
    end else begin
      unique case (s.st)
        tcs_pkg::TCS_IDLE: begin
          next_s.sda_drive = 1'b0;
        end
        tcs_pkg::TCS_ADDR: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], s.sda_s};
            next_s.cnt   = s.cnt + 4'h1;
          end else if (scl_fall && s.cnt == tcs_pkg::BITS_PER_BYTE) begin
            if (addr_hit) begin
              next_s.st        = tcs_pkg::TCS_ADDR_AK;
              next_s.sda_drive = 1'b1;
              next_s.dev_diag  = (s.shreg[7:1] == tcs_pkg::DIAG_ADDR);
              next_s.rw        = s.shreg[0];
            end else begin
              next_s.st = tcs_pkg::TCS_IDLE;
            end
          end
        end
        tcs_pkg::TCS_ADDR_AK: begin
          if (scl_fall) begin
            next_s.cnt = 4'h0;
            if (s.rw) begin
              next_s.st        = tcs_pkg::TCS_RD;
              next_s.shreg     = rd_byte;
              next_s.sda_drive = ~rd_byte[7];
            end else begin
              next_s.st        = tcs_pkg::TCS_WR;
              next_s.first     = 1'b1;
              next_s.sda_drive = 1'b0;
            end
          end
        end
        tcs_pkg::TCS_WR: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], s.sda_s};
            next_s.cnt   = s.cnt + 4'h1;
          end else if (scl_fall && s.cnt == tcs_pkg::BITS_PER_BYTE) begin
            next_s.st        = tcs_pkg::TCS_WR_AK;
            next_s.sda_drive = 1'b1;
            if (s.first) begin
              next_s.ptr   = s.shreg;
              next_s.first = 1'b0;
            end else begin
              if (s.dev_diag &&
                  s.ptr == tcs_pkg::DIAG_CTRL_STATUS_OFFSET) begin
                next_s.pend     = 1'b1;
                next_s.pend_val = s.shreg[tcs_pkg::SOFT_DISABLE_BIT];
              end
              next_s.ptr = s.ptr + 8'h01;
            end
          end
        end
        tcs_pkg::TCS_WR_AK: begin
          if (scl_fall) begin
            next_s.st        = tcs_pkg::TCS_WR;
            next_s.cnt       = 4'h0;
            next_s.sda_drive = 1'b0;
          end
        end
        tcs_pkg::TCS_RD: begin
          if (scl_rise) begin
            next_s.cnt = s.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s.cnt == tcs_pkg::BITS_PER_BYTE) begin
              next_s.st        = tcs_pkg::TCS_RD_AK;
              next_s.sda_drive = 1'b0;
              next_s.ptr       = s.ptr + 8'h01;
            end else begin
              next_s.shreg     = {s.shreg[6:0], 1'b0};
              next_s.sda_drive = ~s.shreg[6];
            end
          end
        end
        tcs_pkg::TCS_RD_AK: begin
          if (scl_rise) begin
            next_s.nack = s.sda_s;
          end else if (scl_fall) begin
            if (s.nack) begin
              next_s.st = tcs_pkg::TCS_IDLE;
            end else begin
              next_s.st        = tcs_pkg::TCS_RD;
              next_s.cnt       = 4'h0;
              next_s.shreg     = rd_byte;
              next_s.sda_drive = ~rd_byte[7];
            end
          end
        end
        default: begin
          next_s.st        = tcs_pkg::TCS_IDLE;
          next_s.sda_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign o_sda_out             = s.sda_out;
  assign o_sda_oe              = s.sda_drive;
  assign o_laser_on            = s.laser_on;
  assign o_tx_fault            = s.fault;
  assign o_receive_signal_lost = s.lost;

endmodule : tcs_top

//--- verification/tcs_top_props.sv
// Port checker for the transceiver control/status block.
// Assumes one clock domain; bound to tcs_top after the module.
`timescale 1ns/1ps
module tcs_top_props #(
  parameter logic [25:0] P_INIT_CYC   = tcs_pkg::T_INIT_CYC,
  parameter logic [25:0] P_SERIAL_CYC = tcs_pkg::T_SERIAL_CYC,
  parameter logic [25:0] P_DATA_CYC   = tcs_pkg::T_DATA_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_tx_disable,
  input wire logic i_laser_fault,
  input wire logic i_signal_present,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_laser_on,
  input wire logic o_tx_fault,
  input wire logic o_receive_signal_lost
);
  // Cycles since reset release, saturating
  logic [25:0] up_cyc;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      up_cyc <= 26'h0;
    else if (up_cyc != 26'h3FFFFFF)
      up_cyc <= up_cyc + 26'h1;
  end
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  init_dark_a: assert property (
    up_cyc < P_INIT_CYC - 26'h2 |-> !o_laser_on)
    else $error("laser on before init");
  bus_quiet_a: assert property (
    up_cyc < P_SERIAL_CYC - 26'h2 |-> !o_sda_oe)
    else $error("bus answered before ready");
  laser_off_a: assert property (
    i_tx_disable [*6] |-> !o_laser_on)
    else $error("laser on while disabled");
  fault_pin_a: assert property (
    (i_laser_fault && !i_tx_disable && o_laser_on) ##1
    (i_laser_fault && !i_tx_disable) [*4] |-> o_tx_fault)
    else $error("fault pin late");
  fault_hold_a: assert property (
    (o_tx_fault && !i_tx_disable) [*6] |=> o_tx_fault)
    else $error("fault cleared without disable");
  lost_pin_a: assert property (
    !i_signal_present [*6] |-> o_receive_signal_lost)
    else $error("signal lost pin late");
  found_pin_a: assert property (
    i_signal_present [*6] |-> !o_receive_signal_lost)
    else $error("signal lost pin stuck");
  sda_low_a: assert property (o_sda_out == 1'b0)
    else $error("data line driven high");
endmodule : tcs_top_props
bind tcs_top tcs_top_props #(
  .P_INIT_CYC(P_INIT_CYC), .P_SERIAL_CYC(P_SERIAL_CYC),
  .P_DATA_CYC(P_DATA_CYC)
) u_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_tx_disable(i_tx_disable),
  .i_laser_fault(i_laser_fault), .i_signal_present(i_signal_present),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_laser_on(o_laser_on), .o_tx_fault(o_tx_fault),
  .o_receive_signal_lost(o_receive_signal_lost)
);

//--- verification/tcs_host.sv
// Host model: drives the two-wire clock and data lines of the block.
// Assumes SDA has a pull-up; SCL idles high between frames.
`timescale 1ns/1ps
module tcs_host (
  input  wire logic i_clk,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  logic drv_low;
  // Wired-AND of both open-drain drivers with the pull-up
  assign o_sda = !(drv_low || i_sda_oe);
  initial begin
    o_scl = 1'b1;
    drv_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge i_clk);
  endtask : w
  // Data moves only mid-low so no false start or stop is seen
  task automatic put_bit(input logic b, output logic r);
    w(2);
    drv_low = !b;
    w(2);
    o_scl = 1'b1;
    w(4);
    r = o_sda;
    o_scl = 1'b0;
  endtask : put_bit
  task automatic start();
    w(2);
    drv_low = 1'b0;
    w(2);
    o_scl = 1'b1;
    w(4);
    drv_low = 1'b1;
    w(4);
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    w(2);
    drv_low = 1'b1;
    w(2);
    o_scl = 1'b1;
    w(4);
    drv_low = 1'b0;
    w(16);
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
    put_bit(last, a);
    ack = !a;
  endtask : xfer
endmodule : tcs_host

//--- verification/tcs_top_bench.sv
// Bench for the transceiver control/status block: pins and status byte.
// Assumes the host model drives the serial bus; power-up counts are shortened.
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    n_tests++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, a, e); \
    end \
  end
module tcs_top_bench;
  localparam logic [25:0] INIT_CYC = 26'h64;
  localparam logic [25:0] DATA_CYC = 26'h3E8;
  logic clk, rst_b, tx_dis, fault, sig_ok, scl, sda;
  logic sda_out, sda_oe, laser_on, tx_fault, lost;
  int   n_tests, miscompares;
  tcs_top #(
    .P_INIT_CYC(INIT_CYC), .P_SERIAL_CYC(INIT_CYC), .P_DATA_CYC(DATA_CYC)
  ) DUT (
    .i_clk(clk), .i_rst_b(rst_b), .i_tx_disable(tx_dis),
    .i_laser_fault(fault), .i_signal_present(sig_ok), .i_scl(scl),
    .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_laser_on(laser_on), .o_tx_fault(tx_fault),
    .o_receive_signal_lost(lost)
  );
  tcs_host host (.i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic probe(input logic [6:0] adr, input logic e);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xfer({adr, 1'b0}, 1'b1, r, a);
    host.stop();
    `CHK(a, e)
  endtask : probe
  task automatic point(output logic ok);
    logic [7:0] r;
    logic       a, b;
    host.start();
    host.xfer({tcs_pkg::DIAG_ADDR, 1'b0}, 1'b1, r, a);
    host.xfer(tcs_pkg::DIAG_CTRL_STATUS_OFFSET, 1'b1, r, b);
    ok = a & b;
  endtask : point
  task automatic reg_wr(input logic [7:0] d);
    logic [7:0] r;
    logic       a, ok;
    point(ok);
    host.xfer(d, 1'b1, r, a);
    host.stop();
    `CHK(ok & a, 1'b1)
  endtask : reg_wr
  // Final master NACK ends the read after one byte
  task automatic reg_rd(input logic [7:0] e);
    logic [7:0] r;
    logic       a, b, ok;
    point(ok);
    host.start();
    host.xfer({tcs_pkg::DIAG_ADDR, 1'b1}, 1'b1, r, a);
    host.xfer(8'hFF, 1'b1, r, b);
    host.stop();
    `CHK(ok & a, 1'b1)
    `CHK(r, e)
  endtask : reg_rd
  // Expected order: laser on, fault pin, signal-lost pin
  task automatic pins(input logic [2:0] e);
    repeat (8) @(negedge clk);
    `CHK({laser_on, tx_fault, lost}, e)
  endtask : pins
  initial begin
    {tx_dis, fault, sig_ok, rst_b} = 4'h2;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    probe(tcs_pkg::DIAG_ADDR, 1'b0);
    for (int k = 0; k < 300 && laser_on !== 1'b1; k++) @(negedge clk);
    `CHK(laser_on, 1'b1)
    if (laser_on !== 1'b1) wrap_up();
    probe(tcs_pkg::ID_ADDR, 1'b1);
    probe(7'h52, 1'b0);
    reg_rd(8'h01);
    repeat (600) @(negedge clk);
    reg_rd(8'h00);
    sig_ok = 1'b0;
    pins(3'h5);
    reg_rd(8'h02);
    sig_ok = 1'b1;
    pins(3'h4);
    reg_rd(8'h00);
    tx_dis = 1'b1;
    pins(3'h0);
    reg_rd(8'h80);
    tx_dis = 1'b0;
    pins(3'h4);
    reg_wr(8'hFF);
    pins(3'h0);
    reg_rd(8'h40);
    reg_wr(8'h00);
    pins(3'h4);
    fault = 1'b1;
    pins(3'h2);
    reg_rd(8'h04);
    fault = 1'b0;
    tx_dis = 1'b1;
    repeat (100) @(negedge clk);
    tx_dis = 1'b0;
    pins(3'h2);
    tx_dis = 1'b1;
    repeat (410) @(negedge clk);
    tx_dis = 1'b0;
    pins(3'h4);
    wrap_up();
  end
endmodule : tcs_top_bench
